// ---- inc/erase_seq_pkg.sv ----
/*
 * Constants, command codes and state type for the bulk erase and erase-verify
 * sequencer that drives a byte-wide parallel flash through its pins.
 * Assumes a single 250 MHz clock and a synchronous active-high reset.
 */
// Overview of operation
// [RULE_01] First 20h write only arms erase; array untouched.
// [RULE_02] Second consecutive 20h write starts parallel erase at its rising strobe.
// [RULE_03] Second erase write carries no address; address bus is don't-care.
// [RULE_04] Host ends every erase pulse by writing A0h.
// [RULE_05] Erase happens only with program supply high and valid control pins.
// [RULE_06] Host ensures all bytes are 00h before erasing.
// [RULE_07] Host writes A0h with the byte address; its rising strobe ends erase.
// [RULE_08] Verify address captured at later falling edge of strobe or select.
// [RULE_09] Verify read returns FFh only when every bit is erased.
// [RULE_10] Host issues a fresh verify command per byte address.
// [RULE_11] Host steps bytes, stopping at a failing byte or the last one.
// [RULE_12] On failure host re-erases, then resumes at the failing address.
// [RULE_13] Verification starts at 0000h and climbs to the last address.
// [RULE_14] Host applies at most 1000 erase pulses per reprogram cycle.
// [RULE_15] Host waits 6 us after each verify command before reading.
// [RULE_16] Host times 10 ms from the second erase strobe before verify.
// [RULE_17] Device stop timer caps each erase pulse at 10 ms.
// [RULE_18] Verify is issued only after a chip erase.
// [RULE_19] After full verify host writes another command, such as FFh reset.
// [RULE_20] Without high program supply the command register holds read mode.
// [RULE_21] Writes need gate high, select and strobe low; data taken on strobe rise.
// [RULE_22] Verify-mode reads return the captured address data regardless of address.
// [RULE_23] Device holds its state until a new valid command; FFh returns to read.
package erase_seq_pkg;
    localparam logic [7:0]  CMD_ERASE     = 8'h20;
    localparam logic [7:0]  CMD_VERIFY    = 8'ha0;
    localparam logic [7:0]  CMD_RESET     = 8'hff;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam int          CLK_MHZ       = 250;
    localparam int          PULSE_US      = 10000;
    localparam int          PULSE_CYC     = PULSE_US * CLK_MHZ;
    localparam int          SETTLE_US     = 6;
    localparam int          SETTLE_CYC    = SETTLE_US * CLK_MHZ;
    localparam int          MAX_PULSES    = 1000;
    localparam int          START_ADDR    = 0;
    localparam int          SETUP_CYC     = 2;
    localparam int          WE_LOW_CYC    = 4;
    localparam int          HOLD_CYC      = 2;
    localparam int          READ_CYC      = 4;
    localparam int          SUPPLY_RAMP_CYC = 256;
    typedef enum logic [3:0] {
        ST_IDLE, ST_RAMP, ST_SETUP_W, ST_ERASE_W, ST_PULSE, ST_VERIFY_W,
        ST_SETTLE, ST_READ, ST_CHECK, ST_RESET_W, ST_DONE, ST_FAIL
    } seq_state_t;
endpackage

// ---- verilog/bus_writer.sv ----
/*
 * One flash bus cycle engine: a command write (strobe low pulse) or a byte read.
 * Assumes the flash pins are synchronous to clk and the flash meets the
 * configured setup, pulse and access counts.
 */
`timescale 1ns/1ps
module bus_writer
    import erase_seq_pkg::*;
#(
    parameter int AW = 15
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          start,
    input  wire logic          is_read,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [7:0]    data_in,
    input  wire logic [7:0]    dq_in,
    output logic               busy_ff,
    output logic               done_ff,
    output logic [7:0]         rdata_ff,
    output logic [AW-1:0]      addr_ff,
    output logic [7:0]         dq_out_ff,
    output logic               dq_oe_ff,
    output logic               ce_n_ff,
    output logic               we_n_ff,
    output logic               oe_n_ff
);
    logic [3:0] cnt_ff;
    logic       rd_ff;

    // Phases: count through setup, active low, then hold.
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_ff   <= 1'b0;
            done_ff   <= 1'b0;
            cnt_ff    <= 4'h0;
            rd_ff     <= 1'b0;
            addr_ff   <= '0;
            dq_out_ff <= 8'h00;
            dq_oe_ff  <= 1'b0;
            ce_n_ff   <= 1'b1;
            we_n_ff   <= 1'b1;
            oe_n_ff   <= 1'b1;
            rdata_ff  <= 8'h00;
        end else begin
            done_ff <= 1'b0;
            if (!busy_ff) begin
                if (start) begin
                    busy_ff   <= 1'b1;
                    rd_ff     <= is_read;
                    cnt_ff    <= 4'h0;
                    addr_ff   <= addr_in;
                    dq_out_ff <= data_in;
                    dq_oe_ff  <= !is_read;
                    ce_n_ff   <= 1'b0;
                    oe_n_ff   <= 1'b1;
                end
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
                if (cnt_ff == 4'(SETUP_CYC)) begin
                    // Gate stays high for writes so the flash never drives against us.
                    if (rd_ff) begin
                        oe_n_ff <= 1'b0;
                    end else begin
                        we_n_ff <= 1'b0; // RULE_21
                    end
                end else if (cnt_ff == 4'(SETUP_CYC + WE_LOW_CYC)) begin
                    // Command data is taken by the flash on this rising strobe.
                    we_n_ff <= 1'b1; // RULE_21
                    if (rd_ff) begin
                        rdata_ff <= dq_in;
                        oe_n_ff  <= 1'b1;
                    end
                end else if (cnt_ff == 4'(SETUP_CYC + WE_LOW_CYC + HOLD_CYC)) begin
                    busy_ff  <= 1'b0;
                    done_ff  <= 1'b1;
                    dq_oe_ff <= 1'b0;
                    ce_n_ff  <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- verilog/erase_sequencer.sv ----
/*
 * Host-side sequencer for bulk erase and byte-by-byte erase verification of a
 * parallel flash. Drives chip select, write strobe, output gate, address and
 * data pins, and the program supply enable.
 * Assumes the array was already programmed to all zero bytes before start.
 */
`timescale 1ns/1ps
module erase_sequencer
    import erase_seq_pkg::*;
#(
    parameter int AW         = 15,
    parameter int PULSE_CNT  = PULSE_CYC,
    parameter int SETTLE_CNT = SETTLE_CYC,
    parameter int RAMP_CNT   = SUPPLY_RAMP_CYC,
    parameter int PULSE_MAX  = MAX_PULSES
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          start,
    input  wire logic [7:0]    dq_in,
    output logic [AW-1:0]      addr_ff,
    output logic [7:0]         dq_out_ff,
    output logic               dq_oe_ff,
    output logic               ce_n_ff,
    output logic               we_n_ff,
    output logic               oe_n_ff,
    output logic               program_supply_high_ff,
    output logic               busy_ff,
    output logic               done_ff,
    output logic               fail_ff,
    output logic [9:0]         erase_pulse_tally_ff,
    output logic [AW-1:0]      fail_addr_ff
);
    localparam logic [AW-1:0] LAST_ADDR = '1;

    seq_state_t      state_ff;
    logic [AW-1:0]   vaddr_ff;
    logic [23:0]     timer_ff;
    logic            cyc_start_ff;
    logic            cyc_read_ff;
    logic [7:0]      cyc_data_ff;
    logic            bw_busy;
    logic            bw_done;
    logic [7:0]      bw_rdata;
    logic [AW-1:0]   bw_addr;
    logic [7:0]      bw_dq;
    logic            bw_oe;
    logic            bw_ce_n;
    logic            bw_we_n;
    logic            bw_oe_n;

    bus_writer #(.AW(AW)) u_bus (
        .clk       (clk),
        .reset     (reset),
        .start     (cyc_start_ff),
        .is_read   (cyc_read_ff),
        .addr_in   (vaddr_ff),
        .data_in   (cyc_data_ff),
        .dq_in     (dq_in),
        .busy_ff   (bw_busy),
        .done_ff   (bw_done),
        .rdata_ff  (bw_rdata),
        .addr_ff   (bw_addr),
        .dq_out_ff (bw_dq),
        .dq_oe_ff  (bw_oe),
        .ce_n_ff   (bw_ce_n),
        .we_n_ff   (bw_we_n),
        .oe_n_ff   (bw_oe_n)
    );

    // Pins are registered once more so every top output leaves a flip-flop.
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_ff   <= '0;
            dq_out_ff <= 8'h00;
            dq_oe_ff  <= 1'b0;
            ce_n_ff   <= 1'b1;
            we_n_ff   <= 1'b1;
            oe_n_ff   <= 1'b1;
        end else begin
            addr_ff   <= bw_addr;
            dq_out_ff <= bw_dq;
            dq_oe_ff  <= bw_oe;
            ce_n_ff   <= bw_ce_n;
            we_n_ff   <= bw_we_n;
            oe_n_ff   <= bw_oe_n;
        end
    end

    // Sequencing of commands, timing and verify stepping.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff               <= ST_IDLE;
            vaddr_ff               <= '0;
            timer_ff               <= 24'h000000;
            cyc_start_ff           <= 1'b0;
            cyc_read_ff            <= 1'b0;
            cyc_data_ff            <= 8'h00;
            program_supply_high_ff <= 1'b0;
            busy_ff                <= 1'b0;
            done_ff                <= 1'b0;
            fail_ff                <= 1'b0;
            erase_pulse_tally_ff   <= 10'h000;
            fail_addr_ff           <= '0;
        end else begin
            cyc_start_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    // The caller starts a run only once every byte has been programmed to 00h.
                    if (start) begin // RULE_06
                        busy_ff                <= 1'b1;
                        done_ff                <= 1'b0;
                        fail_ff                <= 1'b0;
                        vaddr_ff               <= AW'(START_ADDR); // RULE_13
                        erase_pulse_tally_ff   <= 10'h000;
                        program_supply_high_ff <= 1'b1; // RULE_05
                        timer_ff               <= 24'(RAMP_CNT);
                        state_ff               <= ST_RAMP;
                    end
                end
                ST_RAMP: begin
                    if (timer_ff != 24'h000000) begin
                        timer_ff <= timer_ff - 24'h000001;
                    end else begin
                        cyc_data_ff  <= CMD_ERASE; // RULE_01
                        cyc_read_ff  <= 1'b0;
                        cyc_start_ff <= 1'b1;
                        state_ff     <= ST_SETUP_W;
                    end
                end
                ST_SETUP_W: begin
                    if (bw_done) begin
                        // Second write carries the same code; address content does not matter.
                        cyc_data_ff  <= CMD_ERASE; // RULE_02 RULE_03 RULE_12
                        cyc_start_ff <= 1'b1;
                        state_ff     <= ST_ERASE_W;
                    end
                end
                ST_ERASE_W: begin
                    if (bw_done) begin
                        erase_pulse_tally_ff <= erase_pulse_tally_ff + 10'h001; // RULE_14
                        timer_ff             <= 24'(PULSE_CNT); // RULE_16
                        state_ff             <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (timer_ff != 24'h000000) begin
                        timer_ff <= timer_ff - 24'h000001;
                    end else begin
                        // Verify follows each erase pulse and ends it; each later verify follows the previous verify.
                        cyc_data_ff  <= CMD_VERIFY; // RULE_04 RULE_07 RULE_18
                        cyc_start_ff <= 1'b1;
                        state_ff     <= ST_VERIFY_W;
                    end
                end
                ST_VERIFY_W: begin
                    if (bw_done) begin
                        timer_ff <= 24'(SETTLE_CNT); // RULE_15
                        state_ff <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (timer_ff != 24'h000000) begin
                        timer_ff <= timer_ff - 24'h000001;
                    end else begin
                        cyc_read_ff  <= 1'b1;
                        cyc_start_ff <= 1'b1;
                        state_ff     <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (bw_done) begin
                        cyc_read_ff <= 1'b0;
                        state_ff    <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    cyc_start_ff <= 1'b1;
                    if (bw_rdata == ERASED_BYTE) begin
                        if (vaddr_ff == LAST_ADDR) begin // RULE_11
                            cyc_data_ff <= CMD_RESET; // RULE_19
                            state_ff    <= ST_RESET_W;
                        end else begin
                            // A new verify command goes out for every byte.
                            vaddr_ff    <= vaddr_ff + AW'(1); // RULE_10
                            cyc_data_ff <= CMD_VERIFY;
                            state_ff    <= ST_VERIFY_W;
                        end
                    end else if (erase_pulse_tally_ff >= 10'(PULSE_MAX)) begin // RULE_14
                        fail_ff      <= 1'b1;
                        fail_addr_ff <= vaddr_ff;
                        cyc_data_ff  <= CMD_RESET;
                        state_ff     <= ST_RESET_W;
                    end else begin
                        // Address is kept so verification resumes at the failing byte.
                        cyc_data_ff <= CMD_ERASE; // RULE_12
                        state_ff    <= ST_SETUP_W;
                    end
                end
                ST_RESET_W: begin
                    if (bw_done) begin
                        program_supply_high_ff <= 1'b0; // RULE_20
                        state_ff               <= fail_ff ? ST_FAIL : ST_DONE;
                    end
                end
                ST_DONE, ST_FAIL: begin
                    busy_ff  <= 1'b0;
                    done_ff  <= 1'b1;
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- test/flash_model.sv ----
/*
 * Behavioural byte-wide flash for the erase sequencer bench: command register,
 * two-write erase, erase-verify with margin read, stop timer.
 * Assumes pins synchronous to clk; the bench loads need[] (pulses each byte needs).
 */
`timescale 1ns/1ps
module flash_model
    import erase_seq_pkg::*;
#(
    parameter int AW       = 3,
    parameter int STOP_CNT = 40
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    dq_out,
    input  wire logic          ce_n,
    input  wire logic          we_n,
    input  wire logic          oe_n,
    input  wire logic          supply,
    output logic [7:0]         dq_in
);
    logic [3:0]    need [1<<AW];
    logic [7:0]    cmd, last;
    logic          we_q, sel_q, armed, erasing;
    logic [AW-1:0] lat, vaddr, exp_addr;
    int            stop, pulses, order_err;
    wire           sel = !we_n && !ce_n;
    wire           wr  = we_n && !we_q && !ce_n && oe_n && supply;
    wire           rd  = !ce_n && !oe_n;
    wire [AW-1:0]  ra  = (cmd == CMD_VERIFY) ? vaddr : addr;
    // Released data lines show the inverse of the last value so a stale read cannot pass.
    assign dq_in = rd ? ((need[ra] == 4'h0) ? ERASED_BYTE : 8'h00) : ~last;
    always @(posedge clk) begin
        we_q <= we_n;
        sel_q <= sel;
        last <= dq_in;
        if (sel && !sel_q) lat <= addr;
        stop <= stop + 1;
        if (erasing && stop >= STOP_CNT) erasing <= 1'b0;
        if (reset || !supply) begin
            cmd <= 8'h00;
            armed <= 1'b0;
            erasing <= 1'b0;
        end else if (wr) begin
            cmd <= dq_out;
            armed <= (dq_out == CMD_ERASE) && !armed;
            erasing <= armed && dq_out == CMD_ERASE;
            stop <= 0;
            if (armed && dq_out == CMD_ERASE) begin
                pulses <= pulses + 1;
                for (int i = 0; i < (1 << AW); i++) if (need[i] != 4'h0) need[i] <= need[i] - 4'h1;
            end
            if (dq_out == CMD_VERIFY) begin
                vaddr <= lat;
                // A verify after an erase that the stop timer already ended means the host waited too long.
                order_err <= order_err + int'(lat != exp_addr) + int'(cmd == CMD_ERASE && !erasing);
                exp_addr <= (need[lat] == 4'h0) ? lat + 1'b1 : lat;
            end
        end
        if (reset) begin
            pulses <= 0;
            order_err <= 0;
            exp_addr <= '0;
        end
    end
endmodule

// ---- test/erase_sequencer_assertions.sv ----
/*
 * Pin-level checks of the erase sequencer's bus cycles and command order.
 * Assumes it is bound into erase_sequencer and sees only its ports.
 */
`timescale 1ns/1ps
module erase_sequencer_assertions
    import erase_seq_pkg::*;
#(
    parameter int AW         = 15,
    parameter int PULSE_CNT  = PULSE_CYC,
    parameter int SETTLE_CNT = SETTLE_CYC,
    parameter int PULSE_MAX  = MAX_PULSES
) (
    input wire logic          clk,
    input wire logic          reset,
    input wire logic [AW-1:0] addr_ff,
    input wire logic [7:0]    dq_out_ff,
    input wire logic          dq_oe_ff,
    input wire logic          ce_n_ff,
    input wire logic          we_n_ff,
    input wire logic          oe_n_ff,
    input wire logic          program_supply_high_ff,
    input wire logic          done_ff,
    input wire logic [9:0]    erase_pulse_tally_ff
);
    logic [7:0] last_cmd_ff;
    int         gap_ff;
    always_ff @(posedge clk) begin
        if (reset) last_cmd_ff <= 8'h00;
        else if ($rose(we_n_ff)) last_cmd_ff <= dq_out_ff;
    end
    always_ff @(posedge clk) begin
        if (reset || $rose(we_n_ff)) gap_ff <= 0;
        else gap_ff <= gap_ff + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_write_gate: assert property (!we_n_ff |-> !ce_n_ff && oe_n_ff && dq_oe_ff) else $error("write strobe bad");
    a_addr_stable: assert property (!we_n_ff |-> $stable(addr_ff) && $stable(dq_out_ff)) else $error("addr moved");
    a_supply_on: assert property ($fell(we_n_ff) |-> program_supply_high_ff) else $error("write without supply");
    a_read_quiet: assert property (!oe_n_ff |-> !dq_oe_ff && we_n_ff) else $error("read contention");
    a_pulse_time: assert property ($rose(we_n_ff) && dq_out_ff == CMD_VERIFY && last_cmd_ff == CMD_ERASE
        |-> gap_ff >= PULSE_CNT && gap_ff <= PULSE_CNT + 20) else $error("erase pulse length");
    a_settle_wait: assert property ($fell(oe_n_ff) |-> last_cmd_ff == CMD_VERIFY && gap_ff >= SETTLE_CNT)
        else $error("read too soon");
    a_verify_after: assert property ($rose(we_n_ff) && dq_out_ff == CMD_VERIFY
        |-> last_cmd_ff == CMD_ERASE || last_cmd_ff == CMD_VERIFY) else $error("verify w/o erase");
    a_tally_cap: assert property (erase_pulse_tally_ff <= PULSE_MAX) else $error("too many pulses");
    a_done_reset: assert property (done_ff |-> last_cmd_ff == CMD_RESET) else $error("no reset write");
endmodule
bind erase_sequencer erase_sequencer_assertions #(.AW(AW), .PULSE_CNT(PULSE_CNT), .SETTLE_CNT(SETTLE_CNT),
    .PULSE_MAX(PULSE_MAX)) chk (.clk(clk), .reset(reset), .addr_ff(addr_ff), .dq_out_ff(dq_out_ff),
    .dq_oe_ff(dq_oe_ff), .ce_n_ff(ce_n_ff), .we_n_ff(we_n_ff), .oe_n_ff(oe_n_ff),
    .program_supply_high_ff(program_supply_high_ff), .done_ff(done_ff), .erase_pulse_tally_ff(erase_pulse_tally_ff));

// ---- test/erase_sequencer_tb.sv ----
/*
 * Self-checking bench: erase runs against the flash model, mid-run reset, start while busy.
 * Assumes short counts passed as parameters and a model with eight bytes.
 */
`timescale 1ns/1ps
module erase_sequencer_tb;
    import erase_seq_pkg::*;
    localparam int AW = 3;
    typedef struct {logic [31:0] need; int tally; logic fail; logic [AW-1:0] faddr;} row_t;
    // Nibble i is how many pulses byte i needs; every byte starts programmed to zero.
    row_t rows [4] = '{'{32'h11111111, 1, 1'b0, 3'h0}, '{32'h11211111, 2, 1'b0, 3'h0},
        '{32'h31111113, 3, 1'b0, 3'h0}, '{32'h14111111, 3, 1'b1, 3'h6}};
    logic clk = 1'b0, reset = 1'b1, start = 1'b0;
    logic [7:0] dq_in, dq_out_ff;
    logic [AW-1:0] addr_ff, fail_addr_ff;
    logic dq_oe_ff, ce_n_ff, we_n_ff, oe_n_ff, supply, busy_ff, done_ff, fail_ff;
    logic [9:0] tally;
    int n_mismatch = 0, comparisons = 0;
    always #2 clk = ~clk;
    erase_sequencer #(.AW(AW), .PULSE_CNT(20), .SETTLE_CNT(5), .RAMP_CNT(3), .PULSE_MAX(3)) uut (
        .clk(clk), .reset(reset), .start(start), .dq_in(dq_in), .addr_ff(addr_ff), .dq_out_ff(dq_out_ff),
        .dq_oe_ff(dq_oe_ff), .ce_n_ff(ce_n_ff), .we_n_ff(we_n_ff), .oe_n_ff(oe_n_ff),
        .program_supply_high_ff(supply), .busy_ff(busy_ff), .done_ff(done_ff), .fail_ff(fail_ff),
        .erase_pulse_tally_ff(tally), .fail_addr_ff(fail_addr_ff));
    flash_model #(.AW(AW), .STOP_CNT(40)) model (.clk(clk), .reset(reset), .addr(addr_ff), .dq_out(dq_out_ff),
        .ce_n(ce_n_ff), .we_n(we_n_ff), .oe_n(oe_n_ff), .supply(supply), .dq_in(dq_in));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        reset = 1'b1;
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
    endtask
    task automatic run(input int r, input bit twice);
        int k;
        do_reset();
        for (k = 0; k < 8; k++) model.need[k] = rows[r].need[4*k +: 4];
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        if (twice) begin
            // A start while busy is dropped, so the result must match a single start.
            repeat (50) @(posedge clk);
            #1 start = 1'b1;
            @(posedge clk);
            #1 start = 1'b0;
        end
        for (k = 0; k < 20000 && done_ff !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("done", 32'(done_ff), 32'h1);
        check("fail", 32'(fail_ff), 32'(rows[r].fail));
        check("tally", 32'(tally), rows[r].tally);
        check("pulses", model.pulses, rows[r].tally);
        check("order", model.order_err, 32'h0);
        if (rows[r].fail) check("fail_addr", 32'(fail_addr_ff), 32'(rows[r].faddr));
    endtask
    initial begin
        // A full set of runs takes a few thousand cycles; this leaves wide margin.
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        for (int r = 0; r < 4; r++) run(r, 1'b0);
        run(0, 1'b0);
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        repeat (60) @(posedge clk);
        #1;
        do_reset();
        check("idle_pins", {ce_n_ff, we_n_ff, oe_n_ff, dq_oe_ff, supply, busy_ff}, 32'h38);
        check("idle_tally", 32'(tally), 32'h0);
        run(1, 1'b1);
        test_done();
    end
endmodule
